// ### design/tmsw_config_control.v
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tmsw_defs.vh"

//Contract
//- quad, dual and single arrangements supported
//- serial activity overrides pins until reset
//- eight selectable slave addresses
//- reset pin restores every control register
//- serial: all arrangements, aux independent
//- parallel: quad only, one select
//- pulse-enabled inputs lose termination after switch
//- global termination off bit; default on
//- parallel control keeps terminations enabled
//- boost 6/12 dB, per channel or pin
//- output termination by bit or pin
//- output enable bit or pin tristates outputs
//- current level defaults to pin value
//- four preboost levels via field or pins
//- arrangement set only by serial field
//- quad default, whole group routed
//- quad link chosen by field or pins
//- all four lanes handled identically
//- address is 1001 plus three straps
//- dual selectors share one select, serial only
module tmsw_config_control #(
    parameter PULSE_CYCLES = `TMSW_PULSE_MS * `TMSW_CLK_KHZ
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // serial control lines, watched for address matches
    input wire i2c_scl,
    input wire i2c_sda,
    input wire [2:0] slave_addr_strap,
    // parallel control pins
    input wire [1:0] pin_channel_select,
    input wire pin_boost_level,
    input wire pin_output_term_select,
    input wire pin_output_enable,
    input wire pin_output_current_level,
    input wire [1:0] pin_preboost_level,
    // switch controls towards the analog core
    output reg [1:0] fast_switch_arrangement,
    output reg [3:0] fast_channel_select,
    output reg [15:0] out_source_map,
    output reg fast_output_enable,
    output reg [15:0] input_term_enable,
    output reg [7:0] input_boost_level,
    output reg output_term_select,
    output reg output_current_level,
    output reg [1:0] output_preboost_level,
    output reg [1:0] aux_switch_arrangement,
    output reg [3:0] aux_channel_select,
    output reg parallel_disabled
);

    // counter width covers the full termination pulse
    localparam [31:0] PULSE_FULL = PULSE_CYCLES - 1;
    localparam [23:0] PULSE_LAST = PULSE_FULL[23:0];
    // snoop states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;

    // ----------------------------------------------------------------
    // serial registers
    // ----------------------------------------------------------------
    reg [15:0] input_term_pulse_enable; // per input pulse enables
    reg input_term_global_off; // kills every input termination
    reg [1:0] sm_req; // stored arrangement, held legal
    reg [3:0] ch_req; // stored channel select
    reg en_req; // stored output enable
    reg [7:0] eq_req; // stored boost per channel
    reg oto_req; // stored output termination
    reg ocl_req; // stored current level
    reg [1:0] pe_req; // stored preboost
    reg [1:0] aux_sm_req; // stored aux arrangement
    reg [3:0] aux_ch_req; // stored aux channel
    reg pulse_active; // termination pulse running
    reg [23:0] pulse_cnt; // cycles into the pulse
    reg [1:0] prev_sm; // arrangement seen last cycle
    reg [3:0] prev_ch; // channel seen last cycle

    // snoop registers
    reg [1:0] i2c_state; // address snoop state
    reg scl_q; // previous clock line level
    reg sda_q; // previous data line level
    reg [7:0] i2c_shift; // address byte being collected
    reg [3:0] i2c_bits; // bits taken so far
    reg addr_match; // one-cycle pulse on a match

    // ----------------------------------------------------------------
    // address and bus decode
    // ----------------------------------------------------------------
    wire [6:0] slave_addr = {`TMSW_ADDR_HIGH, slave_addr_strap};
    wire apb_setup = psel & ~penable;
    wire apb_done = psel & penable & pready;
    wire apb_wr = apb_done & pwrite;
    // a bus access or an address match is serial control
    wire serial_event = apb_setup | addr_match;
    wire scl_rise = i2c_scl & ~scl_q;
    wire start_cond = i2c_scl & scl_q & sda_q & ~i2c_sda;
    wire stop_cond = i2c_scl & scl_q & ~sda_q & i2c_sda;
    wire [15:0] next_map; // lane sources before the register

    // arrangements outside the three legal codes fall back to quad
    function [1:0] tmsw_legal_sm;
        input [1:0] v;
        begin
            if (v == `TMSW_SM_DUAL || v == `TMSW_SM_SINGLE) begin
                tmsw_legal_sm = v;
            end else begin
                tmsw_legal_sm = `TMSW_SM_QUAD;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // sticky parallel disable
    // ----------------------------------------------------------------
    // only reset clears it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parallel_disabled <= 1'b0;
        end else if (serial_event) begin
            parallel_disabled <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // address snoop on the serial lines
    // ----------------------------------------------------------------
    // only the address byte is decoded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2c_state <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            i2c_shift <= 8'h00;
            i2c_bits <= 4'h0;
            addr_match <= 1'b0;
        end else begin
            scl_q <= i2c_scl;
            sda_q <= i2c_sda;
            addr_match <= 1'b0;
            if (start_cond) begin
                // start or repeated start begins a new address byte
                i2c_state <= ST_SHIFT;
                i2c_bits <= 4'h0;
            end else if (stop_cond) begin
                i2c_state <= ST_IDLE;
            end else begin
                case (i2c_state)
                    ST_SHIFT: begin
                        if (scl_rise) begin
                            i2c_shift <= {i2c_shift[6:0], i2c_sda};
                            i2c_bits <= i2c_bits + 4'h1;
                            if (i2c_bits == 4'h6) begin
                                i2c_state <= ST_WAIT;
                                // compare the seven address bits just collected
                                if ({i2c_shift[5:0], i2c_sda} == slave_addr) begin
                                    addr_match <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_WAIT: begin
                        // hold until the next start or stop
                        i2c_state <= ST_WAIT;
                    end
                    default: begin
                        i2c_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // registers mirror the pins until the first serial event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_term_pulse_enable <= `TMSW_RST_PULSE_EN;
            input_term_global_off <= 1'b0;
            sm_req <= `TMSW_SM_QUAD;
            ch_req <= `TMSW_RST_CH;
            en_req <= 1'b0;
            eq_req <= `TMSW_RST_EQ;
            oto_req <= 1'b0;
            ocl_req <= 1'b0;
            pe_req <= `TMSW_RST_PE;
            aux_sm_req <= `TMSW_SM_QUAD;
            aux_ch_req <= `TMSW_RST_CH;
        end else if (apb_wr) begin
            // a write beats pin tracking in the same cycle
            if (paddr == `TMSW_OFS_FAST_MODES) begin
                sm_req <= tmsw_legal_sm(pwdata[`TMSW_SM_LSB +: 2]);
                ch_req <= pwdata[`TMSW_CH_LSB +: 4];
                en_req <= pwdata[`TMSW_EN_BIT];
            end else if (paddr == `TMSW_OFS_TERM_PULSE) begin
                input_term_pulse_enable <= pwdata[15:0];
            end else if (paddr == `TMSW_OFS_RX_SET) begin
                eq_req <= pwdata[`TMSW_EQ_LSB +: 8];
                input_term_global_off <= pwdata[`TMSW_TO_BIT];
            end else if (paddr == `TMSW_OFS_TX_SET) begin
                oto_req <= pwdata[`TMSW_OTO_BIT];
                ocl_req <= pwdata[`TMSW_OCL_BIT];
                pe_req <= pwdata[`TMSW_PE_LSB +: 2];
            end else if (paddr == `TMSW_OFS_AUX_MODES) begin
                // aux arrangement is kept apart from the fast one
                aux_sm_req <= tmsw_legal_sm(pwdata[`TMSW_SM_LSB +: 2]);
                aux_ch_req <= pwdata[`TMSW_CH_LSB +: 4];
            end
        end else if (!parallel_disabled) begin
            // one select drives fast and aux paths, quad only
            sm_req <= `TMSW_SM_QUAD;
            ch_req <= {2'b00, pin_channel_select};
            aux_sm_req <= `TMSW_SM_QUAD;
            aux_ch_req <= {2'b00, pin_channel_select};
            en_req <= pin_output_enable;
            eq_req <= {8{pin_boost_level}};
            oto_req <= pin_output_term_select;
            ocl_req <= pin_output_current_level;
            pe_req <= pin_preboost_level;
            input_term_global_off <= 1'b0;
            input_term_pulse_enable <= `TMSW_RST_PULSE_EN;
        end
    end

    // ----------------------------------------------------------------
    // termination pulse after a source switch
    // ----------------------------------------------------------------
    // a new switch restarts the full pulse rather than extending it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_sm <= `TMSW_SM_QUAD;
            prev_ch <= `TMSW_RST_CH;
            pulse_active <= 1'b0;
            pulse_cnt <= 24'h000000;
        end else begin
            prev_sm <= sm_req;
            prev_ch <= ch_req;
            if (sm_req != prev_sm || ch_req != prev_ch) begin
                pulse_active <= 1'b1;
                pulse_cnt <= 24'h000000;
            end else if (pulse_active) begin
                if (pulse_cnt == PULSE_LAST) begin
                    pulse_active <= 1'b0;
                end else begin
                    pulse_cnt <= pulse_cnt + 24'h000001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    // every control leaves through a flip-flop to keep the core glitch free
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_switch_arrangement <= `TMSW_SM_QUAD;
            fast_channel_select <= `TMSW_RST_CH;
            fast_output_enable <= 1'b0;
            input_term_enable <= 16'hffff;
            input_boost_level <= `TMSW_RST_EQ;
            output_term_select <= 1'b0;
            output_current_level <= 1'b0;
            output_preboost_level <= `TMSW_RST_PE;
            aux_switch_arrangement <= `TMSW_SM_QUAD;
            aux_channel_select <= `TMSW_RST_CH;
            out_source_map <= `TMSW_RST_MAP;
        end else begin
            fast_switch_arrangement <= sm_req;
            fast_channel_select <= ch_req;
            fast_output_enable <= en_req;
            if (parallel_disabled) begin
                input_term_enable <= ~({16{input_term_global_off}} |
                    ({16{pulse_active}} & input_term_pulse_enable));
            end else begin
                input_term_enable <= 16'hffff;
            end
            input_boost_level <= eq_req;
            output_term_select <= oto_req;
            output_current_level <= ocl_req;
            output_preboost_level <= pe_req;
            aux_switch_arrangement <= aux_sm_req;
            aux_channel_select <= aux_ch_req;
            out_source_map <= next_map;
        end
    end

    // ----------------------------------------------------------------
    // per-lane source selection
    // ----------------------------------------------------------------
    // input n of link l is number 4*l+n; every lane uses the same rule
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            localparam [31:0] LANE_NUM = lane;
            localparam [1:0] LANE_ID = LANE_NUM[1:0];
            reg [3:0] next_src;
            always @* begin
                next_src = 4'h0;
                case (sm_req)
                    `TMSW_SM_DUAL: begin
                        // both eight-way selectors follow the same select
                        next_src = {ch_req[2:1], LANE_ID[1], ch_req[0]};
                    end
                    `TMSW_SM_SINGLE: begin
                        next_src = ch_req;
                    end
                    default: begin
                        // the whole link moves as one group
                        next_src = {ch_req[1:0], LANE_ID};
                    end
                endcase
            end
            assign next_map[lane*4 +: 4] = next_src;
        end
    endgenerate

    // ----------------------------------------------------------------
    // apb read and response
    // ----------------------------------------------------------------
    // pready rises in the second access cycle; unmapped words read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel & penable & ~pready) begin
                if (paddr == `TMSW_OFS_FAST_MODES) begin
                    prdata <= {25'h0, en_req, sm_req, ch_req};
                end else if (paddr == `TMSW_OFS_TERM_PULSE) begin
                    prdata <= {16'h0000, input_term_pulse_enable};
                end else if (paddr == `TMSW_OFS_RX_SET) begin
                    prdata <= {23'h0, input_term_global_off, eq_req};
                end else if (paddr == `TMSW_OFS_TX_SET) begin
                    prdata <= {28'h0, pe_req, ocl_req, oto_req};
                end else if (paddr == `TMSW_OFS_AUX_MODES) begin
                    prdata <= {26'h0, aux_sm_req, aux_ch_req};
                end else if (paddr == `TMSW_OFS_STATUS) begin
                    // writes here are ignored without error
                    prdata <= {23'h0, pulse_active, slave_addr, parallel_disabled};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### design/tmsw_defs.vh
`ifndef TMSW_DEFS_VH
`define TMSW_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMSW_OFS_FAST_MODES 12'h000
`define TMSW_OFS_TERM_PULSE 12'h004
`define TMSW_OFS_RX_SET 12'h008
`define TMSW_OFS_TX_SET 12'h00c
`define TMSW_OFS_AUX_MODES 12'h010
`define TMSW_OFS_STATUS 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
// fast modes and aux modes: [3:0] channel, [5:4] arrangement
`define TMSW_CH_LSB 0
`define TMSW_SM_LSB 4
`define TMSW_EN_BIT 6
// rx settings: [7:0] boost per channel, [8] global termination off
`define TMSW_EQ_LSB 0
`define TMSW_TO_BIT 8
// tx settings
`define TMSW_OTO_BIT 0
`define TMSW_OCL_BIT 1
`define TMSW_PE_LSB 2
// status: [0] parallel disabled, [7:1] slave address, [8] pulse active
`define TMSW_ST_PD_BIT 0
`define TMSW_ST_ADDR_LSB 1
`define TMSW_ST_PULSE_BIT 8

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define TMSW_SM_QUAD 2'h0
`define TMSW_SM_DUAL 2'h1
`define TMSW_SM_SINGLE 2'h2
`define TMSW_ADDR_HIGH 4'h9
`define TMSW_RST_CH 4'h0
`define TMSW_RST_PULSE_EN 16'h0000
`define TMSW_RST_EQ 8'h00
`define TMSW_RST_PE 2'h0
`define TMSW_RST_MAP 16'h3210

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TMSW_PULSE_MS 100
`define TMSW_CLK_KHZ 100000

`endif

// ### tb/tmsw_cc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port level checks of the switch control block
// ------------------------------------------------------------
module tmsw_cc_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // parallel pins
    input wire logic [1:0] pin_channel_select,
    input wire logic [1:0] pin_preboost_level,
    // controls towards the core
    input wire logic [1:0] fast_switch_arrangement,
    input wire logic [3:0] fast_channel_select,
    input wire logic [15:0] out_source_map,
    input wire logic [15:0] input_term_enable,
    input wire logic [1:0] output_preboost_level,
    input wire logic [1:0] aux_switch_arrangement,
    input wire logic parallel_disabled
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // link and dual group select fields
    logic [1:0] lk;
    logic [2:0] dg;
    assign lk = fast_channel_select[1:0];
    assign dg = fast_channel_select[2:0];

    a_reset_dflt: assert property ($rose(presetn) |->
        out_source_map == 16'h3210 && input_term_enable == 16'hffff)
        else $error("defaults missing after reset");
    a_ready_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not in second access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
        else $error("slave error does not match address");
    a_flag_sticky: assert property (parallel_disabled |=> parallel_disabled)
        else $error("parallel disable flag cleared");
    a_bus_disables: assert property (psel && !penable |-> ##[1:3] parallel_disabled)
        else $error("serial access left pins in control");
    a_par_term: assert property (!parallel_disabled |-> input_term_enable == 16'hffff)
        else $error("termination switched under pin control");
    a_par_quad: assert property (!parallel_disabled |->
        fast_switch_arrangement == 2'h0 && aux_switch_arrangement == 2'h0)
        else $error("non quad arrangement under pin control");
    a_pin_follow: assert property (!parallel_disabled && !$past(parallel_disabled, 3) |->
        fast_channel_select == {2'h0, $past(pin_channel_select, 2)}
        && output_preboost_level == $past(pin_preboost_level, 2))
        else $error("outputs do not follow pins");
    a_dual_lock: assert property (fast_switch_arrangement == 2'h1 |->
        out_source_map == {dg[2:1], 1'b1, dg[0], dg[2:1], 1'b1, dg[0],
        dg[2:1], 1'b0, dg[0], dg[2:1], 1'b0, dg[0]})
        else $error("dual selectors not locked");
    a_single_all: assert property (fast_switch_arrangement == 2'h2 |->
        out_source_map == {4{fast_channel_select}})
        else $error("single arrangement map wrong");
    a_quad_group: assert property (fast_switch_arrangement == 2'h0 |->
        out_source_map == {lk, 2'h3, lk, 2'h2, lk, 2'h1, lk, 2'h0})
        else $error("quad group not routed whole");

    c_dual: cover property (fast_switch_arrangement == 2'h1);
    c_single: cover property (fast_switch_arrangement == 2'h2);
    c_error: cover property (pready && pslverr);
endmodule

bind tmsw_config_control tmsw_cc_asserts u_chk (.pclk, .presetn, .psel, .penable, .paddr,
    .pready, .pslverr, .pin_channel_select, .pin_preboost_level, .fast_switch_arrangement,
    .fast_channel_select, .out_source_map, .input_term_enable, .output_preboost_level,
    .aux_switch_arrangement, .parallel_disabled);
`default_nettype wire

// ### tb/tmsw_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// serial master that only sends an address byte
// ------------------------------------------------------------
module tmsw_i2c_master (
    // sampling clock
    input wire logic pclk,
    // serial lines, idle high by pull-up
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // each phase lasts four cycles so the synchronous snoop sees it
    task automatic phase(input logic c, input logic d);
        scl <= c;
        sda <= d;
        repeat (4) @(posedge pclk);
    endtask
    // start, seven bits msb first, write bit, released ack slot, stop
    task automatic send_addr(input logic [6:0] a);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        for (int i = 6; i >= 0; i--) begin
            phase(1'b0, a[i]);
            phase(1'b1, a[i]);
        end
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        // nobody acks: the pull-up wins
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask
endmodule
`default_nettype wire

// ### tb/tmds_switch_config_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmsw_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module tmds_switch_config_control_tb_top;
    localparam int PULSE = 20;
    // stimulus
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdata, prdata;
    logic [2:0] strap = 3'h5;
    logic [1:0] p_ch = 2'h0, p_pe = 2'h0, fsa, asa, ope;
    logic p_eq = 1'b0, p_oto = 1'b0, p_en = 1'b0, p_ocl = 1'b0, err, pready, pslverr;
    logic scl, sda, foe, ots, ocl, pdis;
    logic [3:0] fcs, acs;
    logic [15:0] map, ite;
    logic [7:0] ibl;
    int fails = 0, samples_checked = 0, cycles = 0;

    always #5 pclk = ~pclk;

    tmsw_config_control #(.PULSE_CYCLES(PULSE)) i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .i2c_scl(scl), .i2c_sda(sda),
        .slave_addr_strap(strap), .pin_channel_select(p_ch), .pin_boost_level(p_eq),
        .pin_output_term_select(p_oto), .pin_output_enable(p_en),
        .pin_output_current_level(p_ocl), .pin_preboost_level(p_pe),
        .fast_switch_arrangement(fsa), .fast_channel_select(fcs), .out_source_map(map),
        .fast_output_enable(foe), .input_term_enable(ite), .input_boost_level(ibl),
        .output_term_select(ots), .output_current_level(ocl), .output_preboost_level(ope),
        .aux_switch_arrangement(asa), .aux_channel_select(acs), .parallel_disabled(pdis));

    tmsw_i2c_master i_master (.pclk, .scl, .sda);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        tick(10);
        `CHK(map, 16'h3210)
        `CHK(ite, 16'hffff)
        `CHK(fsa, 2'h0)
        `CHK(pdis, 1'b0)
        presetn <= 1'b1;
        $display("test reset done");
    endtask
    task automatic t_pins();
        p_ch <= 2'h2;
        p_eq <= 1'b1;
        p_oto <= 1'b1;
        p_ocl <= 1'b1;
        p_en <= 1'b1;
        p_pe <= 2'h3;
        tick(4);
        `CHK(fcs, 4'h2)
        `CHK(map, 16'hba98)
        `CHK(acs, 4'h2)
        `CHK(ibl, 8'hff)
        `CHK(ots, 1'b1)
        `CHK(ocl, 1'b1)
        `CHK(ope, 2'h3)
        `CHK(foe, 1'b1)
        p_en <= 1'b0;
        tick(4);
        `CHK(foe, 1'b0)
        $display("test pins done");
    endtask
    task automatic t_snoop();
        i_master.send_addr({4'h9, strap ^ 3'h1});
        tick(4);
        `CHK(pdis, 1'b0)
        i_master.send_addr({4'h9, strap});
        tick(4);
        `CHK(pdis, 1'b1)
        // pins move but must be ignored now
        p_pe <= 2'h0;
        p_ch <= 2'h0;
        tick(4);
        `CHK(ope, 2'h3)
        `CHK(fcs, 4'h2)
        apb(1'b0, `TMSW_OFS_STATUS, 32'h0);
        `CHK(rdata, 32'h0000009b)
        $display("test snoop done");
    endtask
    task automatic t_modes();
        logic [5:0] cfg [4] = '{6'h15, 6'h27, 6'h01, 6'h31};
        logic [15:0] exp_map [4] = '{16'hbb99, 16'h7777, 16'h7654, 16'h7654};
        logic [1:0] exp_arr [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
        apb(1'b1, `TMSW_OFS_AUX_MODES, 32'h23);
        tick(3);
        `CHK(asa, 2'h2)
        `CHK(acs, 4'h3)
        `CHK(fsa, 2'h0)
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `TMSW_OFS_FAST_MODES, {25'h0, 1'b1, cfg[i]});
            tick(3);
            `CHK(fsa, exp_arr[i])
            `CHK(map, exp_map[i])
            `CHK(foe, 1'b1)
        end
        apb(1'b0, `TMSW_OFS_FAST_MODES, 32'h0);
        `CHK(rdata, 32'h00000041)
        $display("test modes done");
    endtask
    task automatic t_term();
        apb(1'b1, `TMSW_OFS_TERM_PULSE, 32'h8001);
        apb(1'b1, `TMSW_OFS_FAST_MODES, 32'h42);
        tick(3);
        `CHK(ite, 16'h7ffe)
        apb(1'b0, `TMSW_OFS_STATUS, 32'h0);
        `CHK(rdata[8], 1'b1)
        tick(PULSE + 5);
        `CHK(ite, 16'hffff)
        apb(1'b1, `TMSW_OFS_RX_SET, 32'h1a5);
        tick(3);
        `CHK(ite, 16'h0000)
        `CHK(ibl, 8'ha5)
        apb(1'b1, `TMSW_OFS_RX_SET, 32'h0);
        tick(3);
        `CHK(ite, 16'hffff)
        $display("test termination done");
    endtask
    task automatic t_tx();
        // outputs go off before internal termination is dropped
        apb(1'b1, `TMSW_OFS_FAST_MODES, 32'h02);
        apb(1'b1, `TMSW_OFS_TX_SET, 32'h8);
        tick(3);
        `CHK(foe, 1'b0)
        `CHK(ots, 1'b0)
        `CHK(ope, 2'h2)
        apb(1'b0, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rdata, 32'h0)
        apb(1'b1, `TMSW_OFS_STATUS, 32'h0);
        apb(1'b0, `TMSW_OFS_STATUS, 32'h0);
        `CHK(rdata[0], 1'b1)
        $display("test tx done");
    endtask

    // ------------------------------------------------------------
    // sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        do_reset();
        t_pins();
        t_snoop();
        do_reset();
        t_modes();
        t_term();
        t_tx();
        give_verdict();
    end
endmodule
`default_nettype wire
